/* File: rtl/multistate_qudit_discriminator.sv */
// Multi-state qudit discriminator for one readout channel with APB registers
//
// Behaviour
// - Without packing, each port bit drives its selected source: 2q+b, 32 zero, 34 one.
// - Codes 16 to 31 exist only with the wide-qudit option.
// - Packing places qudit bits by rising index, one or two bits each.
// - While packing, per-bit source selectors ignore writes.
// - Discrimination runs only while the channel enable is set.
// - A read-only count gives integrators used by the configuration.
// - A read-only percentage gives the share of integrators used.
// - Per-qudit read-only flag tells if enough integrators are free.
// - A qudit is discriminated only while its own enable is set.
// - Per-qudit read-only list of allocated integrator indices.
// - Per-qudit read-only index of its first integrator.
// - State count writes outside two to four are refused.
// - Only the first d(d-1)/2 thresholds of a qudit are used.
// - Only d-1 weights used; weights clamped to -1.0 .. +1.0.
// - A status bit tells whether enabled qudits fit the integrators.
// - At most 4096 samples are integrated per weight.
module multistate_qudit_discriminator
  import msd_pkg::*;
#(
  parameter int NUM_INTEG  = 16,
  parameter int MAX_LEN    = msd_pkg::INT_LEN_MAX,
  parameter bit WIDE_QUDIT = 1'b1
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // APB slave
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Sample stream
  input  wire logic                readoutStart,
  input  wire logic                sampleValid,
  input  wire logic signed [15:0]  sampleRe,
  input  wire logic signed [15:0]  sampleIm,
  // Digital result port
  output logic [msd_pkg::PORT_BITS-1:0] dioOut,
  output logic                     resultValid,
  output logic                     readoutBusy
);
  import msd_pkg::*;

  localparam int IW    = (NUM_INTEG > 1) ? $clog2(NUM_INTEG) : 1;
  localparam int LW    = $clog2(MAX_LEN) + 1;
  localparam int ACC_W = 32 + LW + 2;
  localparam int SW    = ACC_W - FRAC_BITS;

  if (NUM_INTEG < 1 || NUM_INTEG > 32) begin : g_chk_integ
    $error("NUM_INTEG must lie in 1 to 32");
  end
  if (MAX_LEN < 2 || MAX_LEN > INT_LEN_MAX) begin : g_chk_len
    $error("MAX_LEN must lie in 2 to 4096");
  end

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  logic                    globalEn_q;
  logic                    packed_q;
  logic [LW-1:0]           intLen_q;
  logic [NUM_QUDITS-1:0]   quditEn_q;
  logic [2:0]              nStates_q  [NUM_QUDITS];
  logic [31:0]             thr_q      [NUM_QUDITS][MAX_THR];
  logic [5:0]              src_q      [PORT_BITS];
  logic [4:0]              wInteg_q;
  logic [LW-2:0]           wSample_q;
  logic [1:0]              assignTab  [NUM_QUDITS][TABLE_DEPTH];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic        hit;
  logic [31:0] rdData;
  logic        wrEn;
  logic [3:0]  aQudit;
  logic [2:0]  aThr;
  logic [3:0]  thrQudit;
  logic [4:0]  aBit;
  logic        inNst;
  logic        inStart;
  logic        inIdx;
  logic        inThr;
  logic        inSrc;
  logic [5:0]  usedCount;
  logic [NUM_QUDITS-1:0] fits;
  logic [5:0]  startIdx   [NUM_QUDITS];
  logic [31:0] idxMask    [NUM_QUDITS];
  logic [PORT_BITS-1:0]  dio_q;
  logic [6:0]  usedPct;
  rd_state_t   state_q;

  assign aQudit  = paddr[5:2];
  assign aThr    = paddr[4:2];
  assign aBit    = paddr[6:2];
  assign thrQudit = {paddr[9], paddr[7:5]};
  assign inNst   = paddr[11:6] == BASE_NSTATES[11:6];
  assign inStart = paddr[11:6] == BASE_START[11:6];
  assign inIdx   = paddr[11:6] == BASE_IDXLIST[11:6];
  assign inThr   = (paddr[11:10] == BASE_THR[11:10]) && (paddr[9] != paddr[8])
                   && (paddr[4:2] < 3'(MAX_THR));
  assign inSrc   = paddr[11:7] == BASE_SRC[11:7];

  always_comb begin
    hit    = 1'b1;
    rdData = 32'h0000_0000;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (inNst) begin
      rdData = {29'h0, nStates_q[aQudit]};
    end else if (inStart) begin
      rdData = {26'h0, startIdx[aQudit]};
    end else if (inIdx) begin
      rdData = idxMask[aQudit];
    end else if (inThr) begin
      rdData = thr_q[thrQudit][aThr];
    end else if (inSrc) begin
      rdData = {26'h0, src_q[aBit]};
    end else begin
      case (paddr)
        OFF_CTRL:     rdData = {30'h0, packed_q, globalEn_q};
        OFF_INT_LEN:  rdData = 32'(intLen_q);
        OFF_USED_CNT: rdData = {26'h0, usedCount};
        OFF_USED_PCT: rdData = {25'h0, usedPct};
        OFF_STATUS:   rdData = {30'h0, readoutBusy,
                                usedCount <= 6'(NUM_INTEG)};
        OFF_QEN:      rdData = {16'h0, quditEn_q};
        OFF_QAVAIL:   rdData = {16'h0, fits};
        OFF_WSEL:     rdData = {11'h0, wInteg_q, 16'(wSample_q)};
        OFF_WDATA:    rdData = 32'h0000_0000;
        OFF_ASSIGN:   rdData = 32'h0000_0000;
        OFF_DIO:      rdData = dio_q;
        default:      hit    = 1'b0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wrEn    = psel & penable & pwrite & hit;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdData;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      globalEn_q <= 1'b0;
      packed_q   <= 1'b0;
      intLen_q   <= LW'(MAX_LEN);
      quditEn_q  <= '0;
    end else if (wrEn) begin
      case (paddr)
        OFF_CTRL: begin
          globalEn_q <= pwdata[CTRL_EN_BIT];
          packed_q   <= pwdata[CTRL_PACK_BIT];
        end
        OFF_INT_LEN: begin
          if (pwdata != 32'h0 && pwdata <= 32'(MAX_LEN)) begin
            intLen_q <= pwdata[LW-1:0];
          end
        end
        OFF_QEN: quditEn_q <= pwdata[NUM_QUDITS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int q = 0; q < NUM_QUDITS; q++) begin
        nStates_q[q] <= NSTATES_RST;
        for (int k = 0; k < MAX_THR; k++) begin
          thr_q[q][k] <= 32'h0000_0000;
        end
      end
    end else if (wrEn && inNst) begin
      if (pwdata >= 32'(MIN_STATES) && pwdata <= 32'(MAX_STATES)) begin
        nStates_q[aQudit] <= pwdata[2:0];
      end
    end else if (wrEn && inThr) begin
      thr_q[thrQudit][aThr] <= pwdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int b = 0; b < PORT_BITS; b++) begin
        src_q[b] <= SRC_RST;
      end
    end else if (wrEn && inSrc && !packed_q) begin
      if (pwdata < 32'(CODE_WIDE) || pwdata == 32'(CODE_FIXED0)
          || pwdata == 32'(CODE_FIXED1)
          || (WIDE_QUDIT && pwdata < 32'(CODE_FIXED0))) begin
        src_q[aBit] <= pwdata[5:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wInteg_q  <= 5'h00;
      wSample_q <= '0;
    end else if (wrEn && paddr == OFF_WSEL) begin
      wInteg_q  <= pwdata[WSEL_INT_LSB +: 5];
      wSample_q <= pwdata[LW-2:0];
    end else if (wrEn && paddr == OFF_WDATA) begin
      wSample_q <= wSample_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wrEn && paddr == OFF_ASSIGN) begin
      assignTab[pwdata[ASG_QUDIT_LSB +: 4]][pwdata[5:0]] <= pwdata[ASG_STATE_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // Integrator allocation
  // ----------------------------------------------------------------------
  always_comb begin
    logic [5:0] run;
    logic [5:0] need;
    run = 6'h00;
    need = 6'h00;
    for (int q = 0; q < NUM_QUDITS; q++) begin
      need        = 6'(nStates_q[q] - 3'd1);
      startIdx[q] = run;
      fits[q]     = (7'(run) + 7'(need)) <= 7'(NUM_INTEG);
      idxMask[q]  = 32'h0000_0000;
      for (int i = 0; i < NUM_INTEG; i++) begin
        idxMask[q][i] = quditEn_q[q] && 6'(i) >= run && 6'(i) < run + need;
      end
      if (quditEn_q[q]) begin
        run = run + need;
      end
    end
    usedCount = run;
  end

  assign usedPct = 7'((14'(usedCount) * 14'(PERCENT)) / 14'(NUM_INTEG));

  // ----------------------------------------------------------------------
  // Readout sequence
  // ----------------------------------------------------------------------
  logic [LW-1:0] sampleCnt_q;
  logic          lastSample;

  assign lastSample  = sampleValid && (sampleCnt_q == intLen_q - 1'b1);
  assign readoutBusy = state_q != ST_IDLE;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      sampleCnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sampleCnt_q <= '0;
          if (readoutStart && globalEn_q) begin
            state_q <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (sampleValid) begin
            sampleCnt_q <= sampleCnt_q + 1'b1;
          end
          if (lastSample) begin
            state_q <= ST_DECIDE;
          end
        end
        ST_DECIDE:  state_q <= ST_PUBLISH;
        ST_PUBLISH: state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Integrators with their weight memories
  // ----------------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_q [NUM_INTEG];

  for (genvar i = 0; i < NUM_INTEG; i++) begin : g_integ
    logic [31:0]        wMem [MAX_LEN];
    logic signed [15:0] wRe;
    logic signed [15:0] wIm;
    logic signed [15:0] clampRe;
    logic signed [15:0] clampIm;
    logic signed [32:0] prod;

    assign clampRe = ($signed(pwdata[31:16]) > WEIGHT_POS_ONE) ? WEIGHT_POS_ONE :
                     ($signed(pwdata[31:16]) < WEIGHT_NEG_ONE) ? WEIGHT_NEG_ONE :
                     $signed(pwdata[31:16]);
    assign clampIm = ($signed(pwdata[15:0]) > WEIGHT_POS_ONE) ? WEIGHT_POS_ONE :
                     ($signed(pwdata[15:0]) < WEIGHT_NEG_ONE) ? WEIGHT_NEG_ONE :
                     $signed(pwdata[15:0]);

    always_ff @(posedge clk_sys) begin
      if (wrEn && paddr == OFF_WDATA && wInteg_q == 5'(i)) begin
        wMem[wSample_q] <= {clampRe, clampIm};
      end
    end

    assign wRe  = $signed(wMem[sampleCnt_q[LW-2:0]][31:16]);
    assign wIm  = $signed(wMem[sampleCnt_q[LW-2:0]][15:0]);
    assign prod = 33'(sampleRe * wRe) - 33'(sampleIm * wIm);

    always_ff @(posedge clk_sys) begin
      if (!rstn || (state_q == ST_IDLE)) begin
        acc_q[i] <= '0;
      end else if (state_q == ST_INTEG && sampleValid) begin
        acc_q[i] <= acc_q[i] + ACC_W'(prod);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-qudit discrimination
  // ----------------------------------------------------------------------
  logic [1:0] quditState_q [NUM_QUDITS];

  for (genvar g = 0; g < NUM_QUDITS; g++) begin : g_qudit
    logic [MAX_THR-1:0] cmpBits;
    logic [1:0]         stateNow;
    logic               active;

    assign active = globalEn_q && quditEn_q[g] && fits[g];

    always_comb begin
      logic [2:0]  need;
      logic [2:0]  nThr;
      logic [5:0]  sel;
      logic [5:0]  offs;
      logic signed [SW-1:0] scaled;
      sel     = 6'h00;
      offs    = 6'h00;
      scaled  = '0;
      need    = nStates_q[g] - 3'd1;
      nThr    = (nStates_q[g] == 3'd2) ? 3'd1 :
                (nStates_q[g] == 3'd3) ? 3'd3 : 3'd6;
      cmpBits = '0;
      for (int k = 0; k < MAX_THR; k++) begin
        offs   = (need == 3'd1) ? 6'd0 : (need == 3'd2) ? 6'(k % 2) : 6'(k % 3);
        sel    = startIdx[g] + offs;
        scaled = '0;
        if (sel < 6'(NUM_INTEG)) begin
          scaled = acc_q[sel[IW-1:0]][ACC_W-1:FRAC_BITS];
        end
        if (3'(k) < nThr) begin
          cmpBits[k] = scaled > SW'($signed(thr_q[g][k]));
        end
      end
    end

    assign stateNow = assignTab[g][cmpBits];

    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        quditState_q[g] <= 2'b00;
      end else if (state_q == ST_DECIDE) begin
        quditState_q[g] <= active ? stateNow : 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port bit routing
  // ----------------------------------------------------------------------
  logic [PORT_BITS-1:0] selVec;
  logic [PORT_BITS-1:0] packVec;

  for (genvar b = 0; b < PORT_BITS; b++) begin : g_port
    always_comb begin
      if (src_q[b] < CODE_FIXED0) begin
        selVec[b] = quditState_q[src_q[b][4:1]][src_q[b][0]];
      end else begin
        selVec[b] = src_q[b] == CODE_FIXED1;
      end
    end
  end

  always_comb begin
    logic [5:0] pos;
    pos     = 6'h00;
    packVec = '0;
    for (int q = 0; q < NUM_QUDITS; q++) begin
      if (globalEn_q && quditEn_q[q] && fits[q]) begin
        packVec[pos[4:0]] = quditState_q[q][0];
        pos = pos + 6'd1;
        if (nStates_q[q] > 3'd2) begin
          packVec[pos[4:0]] = quditState_q[q][1];
          pos = pos + 6'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dio_q       <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= state_q == ST_PUBLISH;
      if (state_q == ST_PUBLISH) begin
        dio_q <= packed_q ? packVec : selVec;
      end
    end
  end

  assign dioOut = dio_q;

endmodule

/* File: rtl/msd_pkg.sv */
// Register map, field layout and constants of the multi-state discriminator
package msd_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int          NUM_QUDITS   = 16;
  localparam int          NARROW_QUDIT = 8;
  localparam int          MAX_THR      = 6;
  localparam int          TABLE_DEPTH  = 64;
  localparam int          PORT_BITS    = 32;
  localparam int          INT_LEN_MAX  = 4096;
  localparam int          FRAC_BITS    = 14;
  localparam logic [2:0]  MIN_STATES   = 3'd2;
  localparam logic [2:0]  MAX_STATES   = 3'd4;
  localparam logic signed [15:0] WEIGHT_POS_ONE = 16'sh4000;
  localparam logic signed [15:0] WEIGHT_NEG_ONE = -16'sh4000;
  localparam logic [5:0]  CODE_FIXED0  = 6'h20;
  localparam logic [5:0]  CODE_FIXED1  = 6'h22;
  localparam logic [5:0]  CODE_WIDE    = 6'h10;
  localparam logic [6:0]  PERCENT      = 7'h64;
  // ----------------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_INT_LEN  = 12'h004;
  localparam logic [11:0] OFF_USED_CNT = 12'h008;
  localparam logic [11:0] OFF_USED_PCT = 12'h00c;
  localparam logic [11:0] OFF_STATUS   = 12'h010;
  localparam logic [11:0] OFF_QEN      = 12'h014;
  localparam logic [11:0] OFF_QAVAIL   = 12'h018;
  localparam logic [11:0] OFF_WSEL     = 12'h01c;
  localparam logic [11:0] OFF_WDATA    = 12'h020;
  localparam logic [11:0] OFF_ASSIGN   = 12'h024;
  localparam logic [11:0] OFF_DIO      = 12'h028;
  localparam logic [11:0] BASE_NSTATES = 12'h040;
  localparam logic [11:0] BASE_START   = 12'h080;
  localparam logic [11:0] BASE_IDXLIST = 12'h0c0;
  localparam logic [11:0] BASE_THR     = 12'h100;
  localparam logic [11:0] BASE_SRC     = 12'h300;
  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_PACK_BIT  = 1;
  localparam int          STAT_VALID_BIT = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          WSEL_INT_LSB   = 16;
  localparam int          ASG_QUDIT_LSB  = 16;
  localparam int          ASG_STATE_LSB  = 24;
  localparam logic [2:0]  NSTATES_RST    = 3'd2;
  localparam logic [5:0]  SRC_RST        = CODE_FIXED0;
  // ----------------------------------------------------------------------
  // Readout sequence
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_INTEG   = 4'b0010,
    ST_DECIDE  = 4'b0100,
    ST_PUBLISH = 4'b1000
  } rd_state_t;
endpackage

/* File: testbench/msd_chk.sv */
// Port assertions for the multi-state discriminator
module msd_chk
  import msd_pkg::*;
#(
  parameter int MAX_LEN = 16
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Register bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Readout and result port
  input wire logic        readoutStart,
  input wire logic        sampleValid,
  input wire logic [msd_pkg::PORT_BITS-1:0] dioOut,
  input wire logic        resultValid,
  input wire logic        readoutBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Helpers
  // ------
  logic [1:0]  ctrlQ;
  int unsigned cntQ;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrlQ <= 2'h0;
    end else if (psel && penable && pwrite && paddr == OFF_CTRL) begin
      ctrlQ <= pwdata[1:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!readoutBusy) begin
      cntQ <= 0;
    end else if (sampleValid && cntQ < MAX_LEN) begin
      cntQ <= cntQ + 1;
    end
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_start_runs: assert property (
    readoutStart && !readoutBusy && ctrlQ[0] |=> readoutBusy) else $error("start not taken");
  a_start_blocked: assert property (
    readoutStart && !readoutBusy && !ctrlQ[0] |=> !readoutBusy) else $error("start while off");
  a_sample_cap: assert property (
    resultValid |-> cntQ == MAX_LEN) else $error("wrong sample count");
  a_publish_lat: assert property (
    sampleValid && readoutBusy && cntQ == MAX_LEN - 1 |-> (!resultValid) [*3] ##1 resultValid)
    else $error("result latency wrong");
  a_valid_pulse: assert property (
    resultValid |=> !resultValid) else $error("result pulse too long");
  a_idle_result: assert property (
    resultValid |-> !readoutBusy) else $error("busy at result");
  a_dio_hold: assert property (
    $past(rstn) && !resultValid |-> $stable(dioOut)) else $error("port changed between results");
  a_ctrl_read: assert property (
    psel && !penable && !pwrite && paddr == OFF_CTRL |=> prdata[1:0] == ctrlQ)
    else $error("control readback wrong");
  c_result: cover property (resultValid);
  c_blocked: cover property (readoutStart && !readoutBusy && !ctrlQ[0]);
  c_packed: cover property (resultValid && ctrlQ[1]);
endmodule

bind multistate_qudit_discriminator msd_chk #(.MAX_LEN(MAX_LEN)) chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .readoutStart(readoutStart),
  .sampleValid(sampleValid), .dioOut(dioOut), .resultValid(resultValid),
  .readoutBusy(readoutBusy)
);

/* File: testbench/dio_receiver.sv */
// Controller model that takes result words from the digital port
module dio_receiver
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Digital result port
  input  wire logic [msd_pkg::PORT_BITS-1:0] dioOut,
  input  wire logic        resultValid,
  // Captured results
  output logic      [31:0] lastWord,
  output logic      [15:0] gotCount
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lastWord <= 32'h0;
      gotCount <= 16'h0;
    end else if (resultValid) begin
      lastWord <= dioOut;
      gotCount <= gotCount + 16'h1;
    end
  end
endmodule

/* File: testbench/multistate_qudit_discriminator_bench.sv */
// Self-checking bench for the multi-state discriminator
module multistate_qudit_discriminator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import msd_pkg::*;
  localparam int LEN = 16;
  logic               clk_sys = 1'b0;
  logic               rstn = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               readoutStart = 1'b0;
  logic               sampleValid = 1'b0;
  logic signed [15:0] sampleRe = 16'sh0;
  logic signed [15:0] sampleIm = 16'sh7;
  logic [31:0]        dioOut;
  logic               resultValid;
  logic               readoutBusy;
  logic [31:0]        lastWord;
  logic [15:0]        gotCount;
  logic [31:0]        rdv;
  logic               errv;
  int                 failures = 0;
  int                 nChecks = 0;
  logic [5:0]         srcTab [6] = '{6'h00, 6'h02, 6'h03, 6'h22, 6'h20, 6'h01};
  logic [15:0]        wTab [3] = '{16'h7fff, 16'h4000, 16'h8000};
  always #5 clk_sys = ~clk_sys;
  multistate_qudit_discriminator #(.MAX_LEN(LEN)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .readoutStart(readoutStart), .sampleValid(sampleValid), .sampleRe(sampleRe),
    .sampleIm(sampleIm), .dioOut(dioOut), .resultValid(resultValid), .readoutBusy(readoutBusy)
  );
  dio_receiver rx_u (
    .clk_sys(clk_sys), .rstn(rstn), .dioOut(dioOut), .resultValid(resultValid),
    .lastWord(lastWord), .gotCount(gotCount)
  );
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask
  task automatic readout(input logic signed [15:0] s, input logic [31:0] exp);
    logic [15:0] n0;
    n0 = gotCount;
    readoutStart <= 1'b1;
    @(posedge clk_sys);
    readoutStart <= 1'b0;
    sampleValid <= 1'b1;
    sampleRe <= s;
    repeat (8) @(posedge clk_sys);
    sampleValid <= 1'b0;
    @(posedge clk_sys);
    sampleValid <= 1'b1;
    repeat (8) @(posedge clk_sys);
    sampleValid <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("result count", {16'h0, n0 + 16'h1}, {16'h0, gotCount});
    chk("result word", exp, lastWord);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk("ctrl", OFF_CTRL, 32'h0);
    rdchk("length", OFF_INT_LEN, 32'h10);
    rdchk("src b0", BASE_SRC, 32'h20);
    xfer(1'b1, BASE_NSTATES + 12'h004, 32'h5);
    xfer(1'b1, BASE_NSTATES + 12'h004, 32'h1);
    rdchk("states q1", BASE_NSTATES + 12'h004, 32'h2);
    xfer(1'b1, BASE_NSTATES + 12'h004, 32'h3);
    rdchk("states q1", BASE_NSTATES + 12'h004, 32'h3);
    xfer(1'b1, OFF_QEN, 32'hffff);
    rdchk("used", OFF_USED_CNT, 32'h11);
    rdchk("percent", OFF_USED_PCT, 32'h6a);
    rdchk("status", OFF_STATUS, 32'h0);
    rdchk("avail", OFF_QAVAIL, 32'h7fff);
    rdchk("start q15", BASE_START + 12'h03c, 32'h10);
    xfer(1'b1, OFF_QEN, 32'h3);
    xfer(1'b1, OFF_USED_CNT, 32'h55);
    rdchk("used", OFF_USED_CNT, 32'h3);
    rdchk("percent", OFF_USED_PCT, 32'h12);
    rdchk("status", OFF_STATUS, 32'h1);
    rdchk("start q1", BASE_START + 12'h004, 32'h1);
    rdchk("list q1", BASE_IDXLIST + 12'h004, 32'h6);
    xfer(1'b0, 12'h02c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, errv});
    xfer(1'b0, 12'h001, 32'h0);
    chk("misaligned", 32'h1, {31'h0, errv});
    xfer(1'b1, BASE_SRC + 12'h018, 32'h10);
    xfer(1'b1, BASE_SRC + 12'h018, 32'h21);
    rdchk("src b6", BASE_SRC + 12'h018, 32'h10);
    for (int b = 0; b < 6; b++) xfer(1'b1, BASE_SRC + 12'(4 * b), {26'h0, srcTab[b]});
    xfer(1'b1, BASE_THR, 32'h000000c8);
    xfer(1'b1, BASE_THR + 12'h020, 32'h0);
    xfer(1'b1, BASE_THR + 12'h024, 32'hfffffe70);
    xfer(1'b1, BASE_THR + 12'h028, 32'h000000fa);
    xfer(1'b1, BASE_THR + 12'h02c, 32'hfffffc18);
    rdchk("thr q1 k1", BASE_THR + 12'h024, 32'hfffffe70);
    rdchk("thr q0 k0", BASE_THR, 32'h000000c8);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, OFF_WSEL, 32'(i) << 16);
      repeat (LEN) xfer(1'b1, OFF_WDATA, {wTab[i], 16'h0000});
    end
    for (int e = 0; e < 2; e++) xfer(1'b1, OFF_ASSIGN, 32'(((e ^ 1) << 24) | e));
    for (int e = 0; e < 8; e++) begin
      xfer(1'b1, OFF_ASSIGN, 32'h0001_0000 | 32'(((e % 3) << 24) | e));
    end
    xfer(1'b1, OFF_CTRL, 32'h1);
    readout(16'sh14, 32'h0a);
    readout(16'sh0a, 32'h09);
    xfer(1'b1, OFF_QEN, 32'h1);
    readout(16'sh14, 32'h08);
    xfer(1'b1, OFF_QEN, 32'h3);
    xfer(1'b1, OFF_CTRL, 32'h3);
    readout(16'sh14, 32'h2);
    readout(16'sh0a, 32'h1);
    xfer(1'b1, BASE_SRC, 32'h22);
    rdchk("src packed", BASE_SRC, 32'h0);
    xfer(1'b1, OFF_CTRL, 32'h2);
    readoutStart <= 1'b1;
    @(posedge clk_sys);
    readoutStart <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("busy off", 32'h0, {31'h0, readoutBusy});
    rdchk("dio reg", OFF_DIO, 32'h1);
    tally_and_finish();
  end
endmodule
